// ### verilog/borsc_pkg.sv
`default_nettype none
package borsc_pkg;
	// Register map (byte addresses on the AXI4-Lite slave)
	localparam logic [3:0] PWR_STATUS_OFS  = 4'h0;
	localparam logic [3:0] IRQ_STATUS_OFS  = 4'h4;
	localparam logic [3:0] IRQ_ENABLE_OFS  = 4'h8;
	localparam logic [3:0] IRQ_CLEAR_OFS   = 4'hC;
	// Power control status fields
	localparam int POR_FLAG_BIT = 1;
	localparam int BOR_FLAG_BIT = 0;
	localparam logic [1:0] PWR_RESET_VAL = 2'h0;
	// Interrupt event bits
	localparam int EV_POR_BIT  = 0;
	localparam int EV_BOR_BIT  = 1;
	localparam int EV_REL_BIT  = 2;
	localparam int EV_NUM      = 3;
	// Brown-out enable configuration codes
	localparam logic [1:0] ENCFG_ALWAYS = 2'h3;
	localparam logic [1:0] ENCFG_NOSLP  = 2'h2;
	localparam logic [1:0] ENCFG_SW     = 2'h1;
	// Vectors
	localparam logic [12:0] RESET_VECTOR = 13'h0000;
	localparam logic [12:0] IRQ_VECTOR   = 13'h0004;
	// Timing
	localparam int CLK_MHZ          = 100;
	localparam int PWRT_MS          = 64;
	localparam int PWRT_CYCLES      = PWRT_MS * 1000 * CLK_MHZ;
	localparam int BOR_MIN_NS       = 100;
	localparam int BOR_MIN_CYCLES   = (BOR_MIN_NS * CLK_MHZ + 999) / 1000;
	localparam logic [1:0] AXI_OKAY   = 2'h0;
	localparam logic [1:0] AXI_SLVERR = 2'h2;

	typedef enum logic [2:0] {
		BORSC_ST_POR  = 3'h1,
		BORSC_ST_PWRT = 3'h2,
		BORSC_ST_RUN  = 3'h4
	} borsc_state_e;

	typedef struct packed {
		logic [1:0] enable_cfg;
		logic       level_select;
	} borsc_cfg_s;
endpackage
`default_nettype wire

// ### verilog/borsc_top.sv
// Our own choices: the address map and register access over AXI4-Lite.
`timescale 1ns/100ps
`default_nettype none
module borsc_top #(
	parameter int PWRT_CYCLES = borsc_pkg::PWRT_CYCLES,
	parameter int BOR_MIN_CYCLES = borsc_pkg::BOR_MIN_CYCLES
) (
	input  wire logic             aclk,            // System clock
	input  wire logic             aresetn,         // Sync reset, active low
	input  wire logic             por_event,       // Power-on detected by supply monitor
	input  wire logic             below_threshold, // Comparator: supply under threshold
	input  wire logic             external_master_clear_n, // Master-clear pin, active low
	input  wire logic             sleep_mode,      // Core is sleeping
	input  wire logic             flash_erase,     // Program flash erase in progress
	input  wire borsc_pkg::borsc_cfg_s cfg_in,     // Configuration word bits
	output logic                  threshold_sel,   // Selected comparator level
	output logic                  core_reset,      // Hold core in reset
	output logic [12:0]           reset_vector,    // Fetch address after reset
	output logic [12:0]           irq_vector,      // Interrupt vector address
	output logic                  irq,             // Level interrupt
	input  wire logic [3:0]       s_axi_awaddr,    // AXI4-Lite
	input  wire logic             s_axi_awvalid,   // AXI4-Lite
	output logic                  s_axi_awready,   // AXI4-Lite
	input  wire logic [31:0]      s_axi_wdata,     // AXI4-Lite
	input  wire logic [3:0]       s_axi_wstrb,     // AXI4-Lite
	input  wire logic             s_axi_wvalid,    // AXI4-Lite
	output logic                  s_axi_wready,    // AXI4-Lite
	output logic [1:0]            s_axi_bresp,     // AXI4-Lite
	output logic                  s_axi_bvalid,    // AXI4-Lite
	input  wire logic             s_axi_bready,    // AXI4-Lite
	input  wire logic [3:0]       s_axi_araddr,    // AXI4-Lite
	input  wire logic             s_axi_arvalid,   // AXI4-Lite
	output logic                  s_axi_arready,   // AXI4-Lite
	output logic [31:0]           s_axi_rdata,     // AXI4-Lite
	output logic [1:0]            s_axi_rresp,     // AXI4-Lite
	output logic                  s_axi_rvalid,    // AXI4-Lite
	input  wire logic             s_axi_rready     // AXI4-Lite
);
	// ---------------------------------------------------------------
	// Configuration capture
	// ---------------------------------------------------------------
	borsc_pkg::borsc_cfg_s cfg_r, cfg_nxt;
	logic                  cfg_done_r, cfg_done_nxt;

	always_comb
	begin
		cfg_nxt      = cfg_r;
		cfg_done_nxt = 1'b1;
		if (!cfg_done_r)
			cfg_nxt = cfg_in;
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			cfg_r      <= '0;
			cfg_done_r <= 1'b0;
		end
		else
		begin
			cfg_r      <= cfg_nxt;
			cfg_done_r <= cfg_done_nxt;
		end
	end

	// ---------------------------------------------------------------
	// Brown-out enable decode
	// ---------------------------------------------------------------
	logic [1:0] pwr_flags_r, pwr_flags_nxt;
	logic       bor_enabled;

	always_comb
	begin
		if (flash_erase)
			bor_enabled = 1'b1;
		else if (cfg_r.enable_cfg == borsc_pkg::ENCFG_ALWAYS)
			bor_enabled = 1'b1;
		else if (cfg_r.enable_cfg == borsc_pkg::ENCFG_NOSLP)
			bor_enabled = !sleep_mode;
		else if (cfg_r.enable_cfg == borsc_pkg::ENCFG_SW)
			bor_enabled = pwr_flags_r[borsc_pkg::BOR_FLAG_BIT];
		else
			bor_enabled = 1'b0;
	end

	// Erase forces the lower level, which is select value 0
	assign threshold_sel = flash_erase ? 1'b0 : cfg_r.level_select;
	assign reset_vector  = borsc_pkg::RESET_VECTOR;
	assign irq_vector    = borsc_pkg::IRQ_VECTOR;

	// ---------------------------------------------------------------
	// Brown-out filter and power-up timer
	// ---------------------------------------------------------------
	borsc_pkg::borsc_state_e state_r, state_nxt;
	logic [31:0] low_cnt_r, low_cnt_nxt;
	logic [31:0] pwrt_cnt_r, pwrt_cnt_nxt;
	logic        bor_trip, bor_event, rel_event;

	always_comb
	begin
		low_cnt_nxt = '0;
		if (bor_enabled && below_threshold && low_cnt_r < 32'(BOR_MIN_CYCLES))
			low_cnt_nxt = low_cnt_r + 32'h1;
		else if (bor_enabled && below_threshold)
			low_cnt_nxt = low_cnt_r;
	end

	// A short glitch is ignored in BORSC_ST_RUN, whatever the slew rate behind it; in BORSC_ST_PWRT any low supply restarts the timer
	assign bor_trip = bor_enabled && below_threshold && low_cnt_r >= 32'(BOR_MIN_CYCLES);

	always_comb
	begin
		state_nxt    = state_r;
		pwrt_cnt_nxt = pwrt_cnt_r;
		bor_event    = 1'b0;
		rel_event    = 1'b0;
		case (state_r)
			borsc_pkg::BORSC_ST_POR:
			begin
				pwrt_cnt_nxt = '0;
				if (!below_threshold && external_master_clear_n)
					state_nxt = borsc_pkg::BORSC_ST_PWRT;
			end
			borsc_pkg::BORSC_ST_PWRT:
			begin
				if (bor_trip || below_threshold)
				begin
					state_nxt    = borsc_pkg::BORSC_ST_POR;
					pwrt_cnt_nxt = '0;
					bor_event    = bor_trip;
				end
				else if (pwrt_cnt_r >= 32'(PWRT_CYCLES - 1))
				begin
					state_nxt = borsc_pkg::BORSC_ST_RUN;
					rel_event = 1'b1;
				end
				else
					pwrt_cnt_nxt = pwrt_cnt_r + 32'h1;
			end
			borsc_pkg::BORSC_ST_RUN:
			begin
				if (bor_trip)
				begin
					state_nxt = borsc_pkg::BORSC_ST_POR;
					bor_event = 1'b1;
				end
				else if (!external_master_clear_n)
					state_nxt = borsc_pkg::BORSC_ST_POR;
			end
			default:
				state_nxt = borsc_pkg::BORSC_ST_POR;
		endcase
		if (por_event)
		begin
			state_nxt    = borsc_pkg::BORSC_ST_POR;
			pwrt_cnt_nxt = '0;
		end
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			state_r    <= borsc_pkg::BORSC_ST_POR;
			low_cnt_r  <= '0;
			pwrt_cnt_r <= '0;
		end
		else
		begin
			state_r    <= state_nxt;
			low_cnt_r  <= low_cnt_nxt;
			pwrt_cnt_r <= pwrt_cnt_nxt;
		end
	end

	assign core_reset = (state_r != borsc_pkg::BORSC_ST_RUN);

	// ---------------------------------------------------------------
	// AXI4-Lite slave and registers
	// ---------------------------------------------------------------
	logic [2:0]  irq_stat_r, irq_stat_nxt;
	logic [2:0]  irq_en_r, irq_en_nxt;
	logic [3:0]  awaddr_r, awaddr_nxt;
	logic        aw_got_r, aw_got_nxt;
	logic [31:0] wdata_r, wdata_nxt;
	logic        wstrb0_r, wstrb0_nxt;
	logic        w_got_r, w_got_nxt;
	logic        bvalid_r, bvalid_nxt;
	logic [1:0]  bresp_r, bresp_nxt;
	logic        rvalid_r, rvalid_nxt;
	logic [31:0] rdata_r, rdata_nxt;
	logic [1:0]  rresp_r, rresp_nxt;
	logic        wr_go;
	logic [2:0]  ev_vec, clr_vec;

	assign s_axi_awready = !aw_got_r && !bvalid_r;
	assign s_axi_wready  = !w_got_r && !bvalid_r;
	assign s_axi_arready = !rvalid_r;
	assign wr_go         = aw_got_r && w_got_r && !bvalid_r;
	assign ev_vec        = {rel_event, bor_event, por_event};

	always_comb
	begin
		awaddr_nxt    = awaddr_r;
		aw_got_nxt    = aw_got_r;
		wdata_nxt     = wdata_r;
		wstrb0_nxt    = wstrb0_r;
		w_got_nxt     = w_got_r;
		bvalid_nxt    = bvalid_r;
		bresp_nxt     = bresp_r;
		rvalid_nxt    = rvalid_r;
		rdata_nxt     = rdata_r;
		rresp_nxt     = rresp_r;
		pwr_flags_nxt = pwr_flags_r;
		irq_en_nxt    = irq_en_r;
		clr_vec       = '0;
		if (s_axi_awvalid && s_axi_awready)
		begin
			awaddr_nxt = s_axi_awaddr;
			aw_got_nxt = 1'b1;
		end
		if (s_axi_wvalid && s_axi_wready)
		begin
			wdata_nxt  = s_axi_wdata;
			wstrb0_nxt = s_axi_wstrb[0];
			w_got_nxt  = 1'b1;
		end
		if (wr_go)
		begin
			aw_got_nxt = 1'b0;
			w_got_nxt  = 1'b0;
			bvalid_nxt = 1'b1;
			bresp_nxt  = borsc_pkg::AXI_OKAY;
			if (awaddr_r == borsc_pkg::PWR_STATUS_OFS)
			begin
				if (wstrb0_r)
					pwr_flags_nxt = wdata_r[1:0];
			end
			else if (awaddr_r == borsc_pkg::IRQ_ENABLE_OFS)
			begin
				if (wstrb0_r)
					irq_en_nxt = wdata_r[2:0];
			end
			else if (awaddr_r == borsc_pkg::IRQ_CLEAR_OFS)
			begin
				if (wstrb0_r)
					clr_vec = wdata_r[2:0];
			end
			else if (awaddr_r != borsc_pkg::IRQ_STATUS_OFS)
				bresp_nxt = borsc_pkg::AXI_SLVERR;
		end
		else if (bvalid_r && s_axi_bready)
			bvalid_nxt = 1'b0;
		// Hardware clears win over a same-cycle software write
		if (por_event)
			pwr_flags_nxt[borsc_pkg::POR_FLAG_BIT] = 1'b0;
		if (bor_event)
			pwr_flags_nxt[borsc_pkg::BOR_FLAG_BIT] = 1'b0;
		if (s_axi_arvalid && s_axi_arready)
		begin
			rvalid_nxt = 1'b1;
			rresp_nxt  = borsc_pkg::AXI_OKAY;
			rdata_nxt  = '0;
			if (s_axi_araddr == borsc_pkg::PWR_STATUS_OFS)
				rdata_nxt[1:0] = pwr_flags_r;
			else if (s_axi_araddr == borsc_pkg::IRQ_STATUS_OFS)
				rdata_nxt[2:0] = irq_stat_r;
			else if (s_axi_araddr == borsc_pkg::IRQ_ENABLE_OFS)
				rdata_nxt[2:0] = irq_en_r;
			else if (s_axi_araddr != borsc_pkg::IRQ_CLEAR_OFS)
				rresp_nxt = borsc_pkg::AXI_SLVERR;
		end
		else if (rvalid_r && s_axi_rready)
			rvalid_nxt = 1'b0;
		// Set beats clear on the same cycle
		irq_stat_nxt = (irq_stat_r & ~clr_vec) | ev_vec;
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			awaddr_r    <= '0;
			aw_got_r    <= 1'b0;
			wdata_r     <= '0;
			wstrb0_r    <= 1'b0;
			w_got_r     <= 1'b0;
			bvalid_r    <= 1'b0;
			bresp_r     <= borsc_pkg::AXI_OKAY;
			rvalid_r    <= 1'b0;
			rdata_r     <= '0;
			rresp_r     <= borsc_pkg::AXI_OKAY;
			pwr_flags_r <= borsc_pkg::PWR_RESET_VAL;
			irq_stat_r  <= '0;
			irq_en_r    <= '0;
		end
		else
		begin
			awaddr_r    <= awaddr_nxt;
			aw_got_r    <= aw_got_nxt;
			wdata_r     <= wdata_nxt;
			wstrb0_r    <= wstrb0_nxt;
			w_got_r     <= w_got_nxt;
			bvalid_r    <= bvalid_nxt;
			bresp_r     <= bresp_nxt;
			rvalid_r    <= rvalid_nxt;
			rdata_r     <= rdata_nxt;
			rresp_r     <= rresp_nxt;
			pwr_flags_r <= pwr_flags_nxt;
			irq_stat_r  <= irq_stat_nxt;
			irq_en_r    <= irq_en_nxt;
		end
	end

	assign s_axi_bvalid = bvalid_r;
	assign s_axi_bresp  = bresp_r;
	assign s_axi_rvalid = rvalid_r;
	assign s_axi_rdata  = rdata_r;
	assign s_axi_rresp  = rresp_r;
	assign irq          = |(irq_stat_r & irq_en_r);
endmodule // borsc_top
`default_nettype wire

// ### bench/borsc_supply_mon.sv
`timescale 1ns/100ps
`default_nettype none
// ------------------------------
// Supply monitor and comparator
// ------------------------------
module borsc_supply_mon #(
	parameter int HI_DV  = 27,
	parameter int LO_DV  = 24,
	parameter int POR_DV = 15
) (
	input  wire logic       aclk,            // Clock
	input  wire logic [7:0] supply_dv,       // Supply level, decivolts
	input  wire logic       threshold_sel,   // Level picked by the block
	output logic            below_threshold, // Supply under trip level
	output logic            por_event        // Supply under power-on level
);
	// Registered so the outputs move just after an edge, like a synchronised comparator
	always_ff @(posedge aclk)
	begin
		below_threshold <= supply_dv < (threshold_sel ? HI_DV : LO_DV);
		por_event       <= supply_dv < POR_DV;
	end
endmodule // borsc_supply_mon
`default_nettype wire

// ### bench/borsc_chk.sv
`timescale 1ns/100ps
`default_nettype none
module borsc_chk #(
	parameter int PWRT_CYCLES    = borsc_pkg::PWRT_CYCLES,
	parameter int BOR_MIN_CYCLES = borsc_pkg::BOR_MIN_CYCLES
) (
	input wire logic                  aclk,                    // Clock
	input wire logic                  aresetn,                 // Reset
	input wire logic                  por_event,               // Power-on
	input wire logic                  below_threshold,         // Comparator
	input wire logic                  external_master_clear_n, // Master clear
	input wire logic                  sleep_mode,              // Sleep
	input wire logic                  flash_erase,             // Erase
	input wire borsc_pkg::borsc_cfg_s cfg_in,                  // Config
	input wire logic                  threshold_sel,           // Level
	input wire logic                  core_reset,              // Core reset
	input wire logic [12:0]           reset_vector,            // Vector
	input wire logic [12:0]           irq_vector,              // Vector
	input wire logic                  s_axi_arready,           // AXI
	input wire logic                  s_axi_rvalid,            // AXI
	input wire logic [31:0]           s_axi_rdata,             // AXI
	input wire logic [1:0]            s_axi_rresp              // AXI
);
	int                    quiet_r;
	int                    quiet_nxt;
	int                    low_run_r;
	logic                  cap_done_r;
	logic                  en_exp;
	borsc_pkg::borsc_cfg_s cfg_cap_r;
	// Cycles of steady good supply, the span the power-up timer must see
	always_comb quiet_nxt = (below_threshold || por_event || !external_master_clear_n) ? 0 : quiet_r + 1;
	always_ff @(posedge aclk) quiet_r <= aresetn ? quiet_nxt : 0;
	// Configuration is taken once after reset; later cfg_in changes must not count
	always_ff @(posedge aclk)
	begin
		cap_done_r <= aresetn;
		if (!aresetn)
			cfg_cap_r <= '0;
		else if (!cap_done_r)
			cfg_cap_r <= cfg_in;
	end
	always_comb en_exp = flash_erase || cfg_cap_r.enable_cfg == borsc_pkg::ENCFG_ALWAYS
		|| (cfg_cap_r.enable_cfg == borsc_pkg::ENCFG_NOSLP && !sleep_mode);
	// Length of the current enabled low-supply run, so the filter length stays a parameter
	always_ff @(posedge aclk) low_run_r <= (aresetn && below_threshold && en_exp) ? low_run_r + 1 : 0;
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);
	a_vec_const: assert property (reset_vector == 13'h0000 && irq_vector == 13'h0004)
		else $error("vector wrong");
	a_upper_zero: assert property (s_axi_rvalid && s_axi_rresp == 2'h0 |-> s_axi_rdata[31:3] == 29'h0)
		else $error("upper bits set");
	a_por_reset: assert property (por_event |=> core_reset)
		else $error("power-on did not reset");
	a_level_sel: assert property (cap_done_r
		|-> threshold_sel == (flash_erase ? 1'b0 : cfg_cap_r.level_select))
		else $error("threshold select wrong");
	a_bor_trip: assert property (low_run_r == BOR_MIN_CYCLES && below_threshold && en_exp
		|-> ##[0:2] core_reset)
		else $error("brown-out not tripped");
	a_bor_off: assert property (cap_done_r && !core_reset && !por_event && external_master_clear_n && !en_exp
		&& cfg_cap_r.enable_cfg != borsc_pkg::ENCFG_SW |=> !core_reset)
		else $error("reset while disabled");
	a_pwrt_hold: assert property ($fell(core_reset) |-> quiet_r >= PWRT_CYCLES - 2)
		else $error("released early");
	a_pwrt_end: assert property (quiet_r == PWRT_CYCLES + 4 |-> !core_reset)
		else $error("released late");
	a_ar_ready: assert property (s_axi_arready == !s_axi_rvalid)
		else $error("arready wrong");
endmodule // borsc_chk
bind borsc_top borsc_chk #(
	.PWRT_CYCLES    (PWRT_CYCLES),
	.BOR_MIN_CYCLES (BOR_MIN_CYCLES)
) borsc_chk_i (
	.aclk                    (aclk),
	.aresetn                 (aresetn),
	.por_event               (por_event),
	.below_threshold         (below_threshold),
	.external_master_clear_n (external_master_clear_n),
	.sleep_mode              (sleep_mode),
	.flash_erase             (flash_erase),
	.cfg_in                  (cfg_in),
	.threshold_sel           (threshold_sel),
	.core_reset              (core_reset),
	.reset_vector            (reset_vector),
	.irq_vector              (irq_vector),
	.s_axi_arready           (s_axi_arready),
	.s_axi_rvalid            (s_axi_rvalid),
	.s_axi_rdata             (s_axi_rdata),
	.s_axi_rresp             (s_axi_rresp)
);
`default_nettype wire

// ### bench/tb_top.sv
`timescale 1ns/100ps
`default_nettype none
module tb_top;
	logic aclk = 0, aresetn = 0, ext_clr_n = 1, sleep = 0, flash = 0, por, below, tsel, core_reset, irq;
	logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0, awready, wready, bvalid, arready, rvalid;
	logic [3:0] awaddr = 4'h0, araddr = 4'h0;
	logic [31:0] wdata = 32'h0, rdata, d;
	logic [1:0] bresp, rresp, rsp;
	logic [7:0] supply = 8'h21;
	logic [12:0] rv, iv;
	borsc_pkg::borsc_cfg_s cfg = 3'h0;
	int n_mismatch = 0, samples_checked = 0, cyc = 0;
	// Row: cfg[7:6] level[5] sleep[4] erase[3] flags written[2:1] trip[0]
	logic [7:0] rows [8] = '{8'hE7, 8'hD7, 8'hA5, 8'h96, 8'h26, 8'h44, 8'h47, 8'h2F};
	borsc_top #(.PWRT_CYCLES(50), .BOR_MIN_CYCLES(3)) borsc_top_i (.aclk(aclk), .aresetn(aresetn),
		.por_event(por), .below_threshold(below), .external_master_clear_n(ext_clr_n), .sleep_mode(sleep),
		.flash_erase(flash), .cfg_in(cfg), .threshold_sel(tsel), .core_reset(core_reset), .reset_vector(rv),
		.irq_vector(iv), .irq(irq), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
		.s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
		.s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
		.s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
		.s_axi_rvalid(rvalid), .s_axi_rready(rready));
	borsc_supply_mon borsc_supply_mon_i (.aclk(aclk), .supply_dv(supply), .threshold_sel(tsel),
		.below_threshold(below), .por_event(por));
	initial forever #5 aclk = ~aclk;
	// --------------
	// Shared tasks
	// --------------
	task automatic clk(input int n);
		repeat (n) @(posedge aclk);
	endtask
	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp)
		begin
			n_mismatch++;
			$display("ERROR %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic summarize();
		$display("mismatches %0d checks %0d", n_mismatch, samples_checked);
		if (n_mismatch == 0 && samples_checked > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	task automatic axw(input logic [3:0] a, input logic [31:0] v);
		awaddr <= a; wdata <= v; awvalid <= 1; wvalid <= 1; bready <= 1;
		do
		begin
			clk(1);
			if (awready) awvalid <= 0;
			if (wready) wvalid <= 0;
		end while (!bvalid);
		rsp = bresp; bready <= 0;
		clk(1);
	endtask
	task automatic axr(input logic [3:0] a);
		araddr <= a; arvalid <= 1; rready <= 1;
		do
		begin
			clk(1);
			if (arready) arvalid <= 0;
		end while (!rvalid);
		d = rdata; rsp = rresp; rready <= 0;
		clk(1);
	endtask
	task automatic rel();
		for (int i = 0; i < 90 && core_reset !== 1'b0; i++) clk(1);
		chk("release", core_reset, 0);
	endtask
	task automatic rst(input logic [2:0] c);
		aresetn <= 0; cfg <= c;
		clk(2);
		aresetn <= 1;
		rel();
	endtask
	task automatic dip(input int n, input logic [7:0] lv);
		supply <= lv;
		clk(n);
		supply <= 8'h21;
	endtask
	always @(posedge aclk) if (++cyc == 6000)
	begin
		n_mismatch++;
		summarize();
	end
	// -----------
	// Sequence
	// -----------
	initial
	begin
		foreach (rows[k])
		begin
			rst(rows[k][7:5]);
			sleep <= rows[k][4]; flash <= rows[k][3];
			axw(borsc_pkg::PWR_STATUS_OFS, {30'h0, rows[k][2:1]});
			chk("bresp", rsp, borsc_pkg::AXI_OKAY);
			chk("threshold", tsel, rows[k][3] ? 1'b0 : rows[k][5]);
			dip(8, 8'h14);
			chk("trip", core_reset, rows[k][0]);
			rel();
			axr(borsc_pkg::PWR_STATUS_OFS);
			chk("flags", d, rows[k][0] ? {rows[k][2], 1'b0} : rows[k][2:1]);
			chk("rresp", rsp, borsc_pkg::AXI_OKAY);
			sleep <= 0; flash <= 0;
		end
		rst(3'h0);
		axw(borsc_pkg::IRQ_ENABLE_OFS, 32'h1);
		axw(borsc_pkg::PWR_STATUS_OFS, 32'h3);
		dip(4, 8'h0A);
		rel();
		axr(borsc_pkg::PWR_STATUS_OFS);
		chk("por_flag", d, 32'h1);
		chk("irq_on", irq, 1);
		axw(borsc_pkg::IRQ_ENABLE_OFS, 32'h0);
		chk("irq_masked", irq, 0);
		axw(borsc_pkg::IRQ_CLEAR_OFS, 32'h7);
		axw(borsc_pkg::IRQ_ENABLE_OFS, 32'h7);
		chk("irq_cleared", irq, 0);
		axr(borsc_pkg::IRQ_STATUS_OFS);
		chk("irq_status", d, 32'h0);
		axr(4'h2);
		chk("unmapped", rsp, borsc_pkg::AXI_SLVERR);
		axw(4'h6, 32'h0);
		chk("unmapped_wr", rsp, borsc_pkg::AXI_SLVERR);
		// A second dip inside the timer must push the release out past the first deadline
		rst(3'h6);
		// Run-time config changes must reach neither the enable nor the level
		cfg <= 3'h1;
		dip(8, 8'h14);
		chk("static_cfg", tsel, 1'b0);
		clk(30);
		dip(2, 8'h14);
		clk(45);
		chk("restart", core_reset, 1);
		rel();
		ext_clr_n <= 0;
		clk(3);
		chk("master_clear", core_reset, 1);
		ext_clr_n <= 1;
		rel();
		summarize();
	end
endmodule // tb_top
`default_nettype wire
